// ===== rtl/bst_pkg.sv
// Constants and types shared by the boundary-scan test access port.
package bst_pkg;
  localparam int BST_IR_W = 3;
  localparam int BST_ID_W = 32;
  localparam int BST_BSR_IN = 8;
  localparam int BST_BSR_OUT = 8;
  localparam int BST_BSR_W = BST_BSR_IN + 2 * BST_BSR_OUT;
  localparam logic [2:0] BST_OP_EXTEST = 3'h0;
  localparam logic [2:0] BST_OP_IDCODE = 3'h1;
  localparam logic [2:0] BST_OP_SAMPLE = 3'h2;
  localparam logic [2:0] BST_OP_BYPASS = 3'h7;
  localparam logic [2:0] BST_IR_RST = BST_OP_IDCODE;
  localparam logic [1:0] BST_IR_CAPTURE = 2'h1;
  // Identification value is arbitrary; bit 0 is the mandatory 1.
  localparam logic [31:0] BST_IDCODE = 32'h1234_5679;
  localparam int BST_TRST_MIN_NS = 500;
  localparam int BST_SYS_MHZ = 100;
  localparam int BST_TRST_CYC = (BST_TRST_MIN_NS * BST_SYS_MHZ + 999) / 1000;
  localparam int BST_TCK_MAX_MHZ = 10;
  typedef enum logic [15:0] {
    BST_RESET = 16'h0001, BST_IDLE = 16'h0002, BST_SEL_DR = 16'h0004,
    BST_CAP_DR = 16'h0008, BST_SH_DR = 16'h0010, BST_EX1_DR = 16'h0020,
    BST_PA_DR = 16'h0040, BST_EX2_DR = 16'h0080, BST_UPD_DR = 16'h0100,
    BST_SEL_IR = 16'h0200, BST_CAP_IR = 16'h0400, BST_SH_IR = 16'h0800,
    BST_EX1_IR = 16'h1000, BST_PA_IR = 16'h2000, BST_EX2_IR = 16'h4000,
    BST_UPD_IR = 16'h8000
  } bst_state_e;
endpackage

// ===== rtl/bst_tap.sv
// Boundary-scan test access port with its four shift paths.
`timescale 1ns/10ps
module bst_tap
  import bst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_reset_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BST_BSR_IN-1:0] pin_in,
  output logic [BST_BSR_IN-1:0] core_in,
  input wire logic [BST_BSR_OUT-1:0] core_out,
  input wire logic [BST_BSR_OUT-1:0] core_oe,
  output logic [BST_BSR_OUT-1:0] pin_out,
  output logic [BST_BSR_OUT-1:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the test reset acts asynchronously on scan state.

  logic [1:0] tck_s, tms_s, tdi_s;
  logic tck_d;
  logic trst_n;
  logic trst_m;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_s <= 2'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      tck_d <= 1'b0;
    end
    else
    begin
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      tck_d <= tck_s[1];
    end
  end

  always_ff @(posedge clk_sys or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      trst_m <= 1'b0;
      trst_n <= 1'b0;
    end
    else
    begin
      trst_m <= 1'b1;
      trst_n <= trst_m;
    end
  end

  logic rst_all_n;
  logic tck_rise, tck_fall;
  assign rst_all_n = rst_n & test_reset_n;
  assign tck_rise = tck_s[1] & ~tck_d;
  assign tck_fall = ~tck_s[1] & tck_d;

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine on rising test-clock edges.

  bst_state_e state, next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      BST_RESET: next_state = tms_s[1] ? BST_RESET : BST_IDLE;
      BST_IDLE: next_state = tms_s[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: next_state = tms_s[1] ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: next_state = tms_s[1] ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: next_state = tms_s[1] ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: next_state = tms_s[1] ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR: next_state = tms_s[1] ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: next_state = tms_s[1] ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: next_state = tms_s[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: next_state = tms_s[1] ? BST_RESET : BST_CAP_IR;
      BST_CAP_IR: next_state = tms_s[1] ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: next_state = tms_s[1] ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: next_state = tms_s[1] ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR: next_state = tms_s[1] ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: next_state = tms_s[1] ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: next_state = tms_s[1] ? BST_SEL_DR : BST_IDLE;
      default: next_state = BST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_all_n)
  begin
    if (!rst_all_n)
      state <= BST_RESET;
    else if (!trst_n)
      state <= BST_RESET;
    else if (tck_rise)
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register and path decode.

  logic [BST_IR_W-1:0] ir_sh, ir;

  function automatic logic [1:0] path_of(input logic [BST_IR_W-1:0] op);
    unique case (op)
      BST_OP_EXTEST, BST_OP_SAMPLE: path_of = 2'h1;
      BST_OP_IDCODE: path_of = 2'h2;
      default: path_of = 2'h0;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      ir_sh <= '0;
      ir <= BST_IR_RST;
    end
    else if (tck_rise)
    begin
      if (state == BST_RESET)
        ir <= BST_IR_RST;
      else if (state == BST_UPD_IR)
        ir <= ir_sh;
      if (state == BST_CAP_IR)
        ir_sh <= {1'b0, BST_IR_CAPTURE};
      else if (state == BST_SH_IR)
        ir_sh <= {tdi_s[1], ir_sh[BST_IR_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data shift paths: bypass, identification and boundary.

  logic byp;
  logic [BST_ID_W-1:0] id_sh;
  logic [BST_BSR_W-1:0] bsr_sh, bsr_up;
  logic [BST_BSR_W-1:0] bsr_cap;
  logic [1:0] path;
  logic extest;

  assign path = path_of(ir);
  assign extest = (ir == BST_OP_EXTEST) && (state != BST_RESET);
  assign bsr_cap = {core_oe, core_out, pin_in};

  always_ff @(posedge clk_sys or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      byp <= 1'b0;
      id_sh <= '0;
      bsr_sh <= '0;
    end
    else if (tck_rise)
    begin
      if (state == BST_CAP_DR)
      begin
        byp <= 1'b0;
        id_sh <= BST_IDCODE;
        bsr_sh <= bsr_cap;
      end
      else if (state == BST_SH_DR)
      begin
        byp <= tdi_s[1];
        id_sh <= {tdi_s[1], id_sh[BST_ID_W-1:1]};
        bsr_sh <= {tdi_s[1], bsr_sh[BST_BSR_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_all_n)
  begin
    if (!rst_all_n)
      bsr_up <= '0;
    else if (tck_fall && state == BST_UPD_DR && path == 2'h1)
      bsr_up <= bsr_sh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on falling test-clock edges.

  logic sel_bit;

  always_comb
  begin
    if (state == BST_SH_IR)
      sel_bit = ir_sh[0];
    else unique case (path)
      2'h1: sel_bit = bsr_sh[0];
      2'h2: sel_bit = id_sh[0];
      default: sel_bit = byp;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= sel_bit;
      tdo_oe <= (state == BST_SH_IR) || (state == BST_SH_DR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary cells: transparent unless the external test is active.

  logic drive_bsr;
  logic [BST_BSR_IN-1:0] next_core_in;
  logic [BST_BSR_OUT-1:0] next_pin_out;
  logic [BST_BSR_OUT-1:0] next_pin_oe;

  assign drive_bsr = extest && trst_n;

  for (genvar i = 0; i < BST_BSR_IN; i++)
  begin : g_in_cell
    assign next_core_in[i] = drive_bsr ? bsr_up[i] : pin_in[i];
  end

  for (genvar i = 0; i < BST_BSR_OUT; i++)
  begin : g_out_cell
    assign next_pin_out[i] =
      drive_bsr ? bsr_up[BST_BSR_IN+i] : core_out[i];
    assign next_pin_oe[i] =
      drive_bsr ? bsr_up[BST_BSR_IN+BST_BSR_OUT+i] : core_oe[i];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_in <= '0;
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      core_in <= next_core_in;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

endmodule

// ===== testbench/bst_jtag_ctl.sv
// Test controller model that drives the scan pins.
`timescale 1ns/10ps
module bst_jtag_ctl
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial {tck, tms, tdi} = 3'h3;
  task automatic step(input logic m, input logic d, output logic q);
    {tms, tdi} = {m, d};
    #40 tck = 1'h1;
    #39 q = tdo;
    #1 tck = 1'h0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    dout = '0;
    for (int i = 0; i < 4 + ir; i++)
      step(i == 1 || (ir && i == 2), 1'h1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    {tms, tdi} = 2'h3;
  endtask
endmodule

// ===== testbench/bst_tap_monitor.sv
// Checker of scan port timing and pass-through paths.
`timescale 1ns/10ps
module bst_tap_monitor
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic test_reset_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] core_in,
  input wire logic [7:0] core_out,
  input wire logic [7:0] core_oe,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_tdo_fall: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved with tck high");
  chk_oe_treset: assert property (!test_reset_n |-> !tdo_oe)
    else $error("tdo_oe in test reset");
  chk_oe_quiet: assert property ($rose(test_reset_n)
    |-> (!tdo_oe)[*4]) else $error("early tdo_oe");
  chk_core_pass: assert property ((!test_reset_n)[*2]
    |-> core_in == $past(pin_in)) else $error("core_in not passed");
  chk_pin_pass: assert property ((!test_reset_n)[*2]
    |-> pin_out == $past(core_out)) else $error("pin_out not passed");
  chk_oe_pass: assert property ((!test_reset_n)[*2]
    |-> pin_oe == $past(core_oe)) else $error("pin_oe not passed");
  chk_sys_reset: assert property (disable iff (1'h0) !rst_n
    |-> !tdo && pin_oe == 8'h00) else $error("outputs in reset");
  chk_oe_rise: assert property ($rose(tdo_oe)
    |-> $past(tck, 4) && !$past(tck, 3)) else $error("tdo_oe off tck");
endmodule
bind bst_tap bst_tap_monitor bst_tap_monitor_inst (.clk_sys(clk_sys),
  .rst_n(rst_n), .tck(tck), .test_reset_n(test_reset_n), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in), .core_out(core_out),
  .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== testbench/bst_tap_tb.sv
// Self-checking bench of the boundary-scan test access port.
`timescale 1ns/10ps
module bst_tap_tb
  import bst_pkg::*;;
  logic clk_sys = 1'h0, rst_n, test_reset_n, tck, tms, tdi, tdo;
  logic [7:0] pin_in, core_in, core_out, core_oe, pin_out, pin_oe;
  logic [31:0] got, d, exp_q[$];
  logic [23:0] pat;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  event got_ev;
  always #5 clk_sys = ~clk_sys;
  bst_tap bst_tap_inst (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n), .tdo(tdo),
    .tdo_oe(), .pin_in(pin_in), .core_in(core_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  bst_jtag_ctl bst_jtag_ctl_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got = g;
    -> got_ev;
    #1;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] v,
    input logic [31:0] e);
    bst_jtag_ctl_inst.scan(ir, n, v, d);
    note(e, d);
  endtask
  always @(got_ev)
  begin
    samples_checked++;
    if (exp_q.pop_front() !== got)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h", $time, got);
    end
  end
  always @(posedge clk_sys)
    if (++cycles == 10000) give_verdict(1);
  task automatic give_verdict(input int extra);
    n_fail += extra;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h35E9));
    {rst_n, test_reset_n, pin_in, core_out, core_oe} = '0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'h1;
    repeat (50) @(posedge clk_sys);
    #1 test_reset_n = 1'h1;
    scan(1'h0, 32, '1, BST_IDCODE);
    for (int k = 0; k < 2; k++)
    begin
      scan(1'h1, 3, k ? 32'h5 : 32'(BST_OP_BYPASS), 32'h1);
      pat = 24'($urandom);
      scan(1'h0, 8, 32'(pat), 32'({pat[6:0], 1'h0}));
    end
    scan(1'h1, 3, 32'(BST_OP_SAMPLE), 32'(BST_IR_CAPTURE));
    @(posedge clk_sys) #1 {pin_in, core_out, core_oe} = 24'($urandom);
    scan(1'h0, 24, '0, {8'h00, core_oe, core_out, pin_in});
    note({8'h0, core_oe, core_out, pin_in}, {8'h0, pin_oe, pin_out, core_in});
    scan(1'h1, 3, 32'(BST_OP_EXTEST), 32'(BST_IR_CAPTURE));
    bst_jtag_ctl_inst.scan(1'h0, 24, 32'(pat), d);
    note({8'h0, pat}, {8'h0, pin_oe, pin_out, core_in});
    @(posedge clk_sys) #1 test_reset_n = 1'h0;
    repeat (50) @(posedge clk_sys);
    #1 test_reset_n = 1'h1;
    scan(1'h0, 32, '1, BST_IDCODE);
    give_verdict(0);
  end
endmodule
